/* rtl/apr_defs.svh */
// Offsets, field positions, reset values and bus codes for the alternate pin router
//
// How it works
// - Select bits steer functions between pins
// - Seven relocatable functions, no more
// - Select changes never touch direction registers
// - Overrides follow the currently selected pin
// - Unselected pin sees no function influence
// - Small package moves pwm2 B to port_b_pin5
`ifndef APR_DEFS_SVH
`define APR_DEFS_SVH

// Register byte offsets within the slave window
`define APR_CTRL_OFFSET   12'h000
`define APR_STAT_OFFSET   12'h004

// Control register layout
`define APR_CTRL_RESET    8'h00
`define APR_CTRL_MASK     8'h7f
`define APR_SEL_CAPTURE2  0
`define APR_SEL_SLAVE_SEL 1
`define APR_SEL_COMP2     2
`define APR_SEL_LATCH_INV 3
`define APR_SEL_PWM2_B    4
`define APR_SEL_TMR1_GATE 5
`define APR_SEL_CAPTURE3  6
`define APR_NUM_FUNC      7

// Status register layout
`define APR_STAT_SEL_LSB  0
`define APR_STAT_LVL_LSB  8

// Bus codes
`define APR_HTRANS_NONSEQ 2'h2
`define APR_HTRANS_SEQ    2'h3
`define APR_HRESP_OKAY    1'h0

`endif

/* rtl/apr_pkg.sv */
// Types shared by the alternate pin router files
package apr_pkg;

	// Override bundle that a function applies to one pin
	typedef struct packed {
		logic port_ovr;
		logic port_val;
		logic dir_ovr;
		logic dir_val;
	} apr_pin_ovr_t;

	// Address phase of an AHB-Lite transfer as seen by the slave
	typedef struct packed {
		logic        sel;
		logic [1:0]  trans;
		logic        write;
		logic [2:0]  size;
		logic [11:0] addr;
	} apr_ahb_req_t;

	// Data phase kind
	typedef enum logic [1:0] {
		APR_PH_IDLE,
		APR_PH_READ,
		APR_PH_WRITE
	} apr_phase_t;

endpackage : apr_pkg

/* rtl/apr_route_out.sv */
// Output side steering of one function onto its default or alternate pin
`timescale 1ns/100ps

module apr_route_out (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// Select and function request
	input  wire logic                  sel,
	input  wire apr_pkg::apr_pin_ovr_t drive,
	// Pin overrides
	output apr_pkg::apr_pin_ovr_t      dflt_ovr,
	output apr_pkg::apr_pin_ovr_t      alt_ovr
);

	apr_pkg::apr_pin_ovr_t next_dflt_ovr;
	apr_pkg::apr_pin_ovr_t next_alt_ovr;

	always_comb begin
		// Idle pin gets an all-clear bundle so its own port logic rules it
		next_dflt_ovr = sel ? '0 : drive;
		next_alt_ovr  = sel ? drive : '0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dflt_ovr <= '0;
			alt_ovr  <= '0;
		end else begin
			dflt_ovr <= next_dflt_ovr;
			alt_ovr  <= next_alt_ovr;
		end
	end

endmodule : apr_route_out

/* rtl/apr_route_in.sv */
// Input side steering: the function hears only its selected pin
`timescale 1ns/100ps

module apr_route_in (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Select and pin levels
	input  wire logic sel,
	input  wire logic level_dflt,
	input  wire logic level_alt,
	// Level delivered to the function
	output logic      level
);

	logic next_level;

	always_comb begin
		next_level = sel ? level_alt : level_dflt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level <= 1'b0;
		end else begin
			level <= next_level;
		end
	end

endmodule : apr_route_in

/* rtl/apr_pin_steer.sv */
// Alternate pin router: AHB-Lite register slave and per-function pin steering
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "apr_defs.svh"

module apr_pin_steer #(
	parameter int          NUM_FUNC  = `APR_NUM_FUNC,
	parameter bit          SMALL_PKG = 1'b1
) (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	// Peripheral side, indexed by select bit position
	input  wire apr_pkg::apr_pin_ovr_t periph_drive [NUM_FUNC],
	output logic                       periph_level [NUM_FUNC],
	// Pin side, default and alternate pin of each function
	input  wire logic                  pin_level_dflt [NUM_FUNC],
	input  wire logic                  pin_level_alt  [NUM_FUNC],
	output apr_pkg::apr_pin_ovr_t      pin_ovr_dflt   [NUM_FUNC],
	output apr_pkg::apr_pin_ovr_t      pin_ovr_alt    [NUM_FUNC],
	// Large package alternate pin for pwm2 output B
	output apr_pkg::apr_pin_ovr_t      port_d_pin2_ovr
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode helpers

	function automatic logic apr_is_ctrl(input logic [11:0] addr);
		apr_is_ctrl = (addr[11:2] == 10'(`APR_CTRL_OFFSET >> 2));
	endfunction : apr_is_ctrl

	function automatic logic apr_is_stat(input logic [11:0] addr);
		apr_is_stat = (addr[11:2] == 10'(`APR_STAT_OFFSET >> 2));
	endfunction : apr_is_stat

	////////////////////////////////////////////////////////////////////////////////
	// Bus state

	apr_pkg::apr_ahb_req_t req;
	apr_pkg::apr_phase_t   phase;
	apr_pkg::apr_phase_t   next_phase;
	logic [11:0]           dph_addr;
	logic [11:0]           next_dph_addr;
	logic [7:0]            ctrl;
	logic [7:0]            next_ctrl;
	logic [31:0]           next_hrdata;
	logic                  take;
	logic [31:0]           stat_word;
	logic [31:0]           periph_level_word;
	logic [NUM_FUNC-1:0]   applied_sel;

	always_comb begin
		req.sel   = hsel;
		req.trans = htrans;
		req.write = hwrite;
		req.size  = hsize;
		req.addr  = haddr[11:0];
	end

	// Zero wait states: every transfer completes in one data phase
	assign hreadyout = 1'b1;
	assign hresp     = `APR_HRESP_OKAY;

	assign take = req.sel && hready &&
		(req.trans == `APR_HTRANS_NONSEQ || req.trans == `APR_HTRANS_SEQ);

	////////////////////////////////////////////////////////////////////////////////
	// Phase tracking and register write

	always_comb begin
		next_phase    = phase;
		next_dph_addr = dph_addr;
		next_ctrl     = ctrl;
		// Write lands at the end of its data phase
		if (phase == apr_pkg::APR_PH_WRITE && apr_is_ctrl(dph_addr)) begin
			// Only the select bits touch this register; direction state lives elsewhere
			next_ctrl = hwdata[7:0] & `APR_CTRL_MASK;
		end
		if (hready) begin
			if (take) begin
				next_phase    = req.write ? apr_pkg::APR_PH_WRITE : apr_pkg::APR_PH_READ;
				next_dph_addr = req.addr;
			end else begin
				next_phase = apr_pkg::APR_PH_IDLE;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase    <= apr_pkg::APR_PH_IDLE;
			dph_addr <= 12'h000;
			ctrl     <= `APR_CTRL_RESET;
		end else begin
			phase    <= next_phase;
			dph_addr <= next_dph_addr;
			ctrl     <= next_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	// Selects actually in force on the pins, lagging ctrl by one cycle
	logic [NUM_FUNC-1:0] next_applied_sel;

	always_comb begin
		next_applied_sel = ctrl[NUM_FUNC-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			applied_sel <= '0;
		end else begin
			applied_sel <= next_applied_sel;
		end
	end

	always_comb begin
		periph_level_word = 32'h0000_0000;
		for (int i = 0; i < NUM_FUNC; i++) begin
			periph_level_word[i] = periph_level[i];
		end
		stat_word = 32'h0000_0000;
		stat_word[`APR_STAT_SEL_LSB +: NUM_FUNC] = applied_sel;
		stat_word[`APR_STAT_LVL_LSB +: NUM_FUNC] = periph_level_word[NUM_FUNC-1:0];
	end

	// Read value is built from next_ctrl so a write just before is seen at once
	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (take && !req.write) begin
			if (apr_is_ctrl(req.addr)) begin
				next_hrdata = {24'h00_0000, next_ctrl};
			end else if (apr_is_stat(req.addr)) begin
				next_hrdata = stat_word;
			end else begin
				next_hrdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-function steering; index order matches the select bit positions

	apr_pkg::apr_pin_ovr_t route_dflt [NUM_FUNC];
	apr_pkg::apr_pin_ovr_t route_alt  [NUM_FUNC];

	for (genvar g = 0; g < NUM_FUNC; g++) begin : g_func
		apr_route_out u_out (
			.hclk     (hclk),
			.hresetn  (hresetn),
			.sel      (ctrl[g]),
			.drive    (periph_drive[g]),
			.dflt_ovr (route_dflt[g]),
			.alt_ovr  (route_alt[g])
		);
		apr_route_in u_in (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.sel        (ctrl[g]),
			.level_dflt (pin_level_dflt[g]),
			.level_alt  (pin_level_alt[g]),
			.level      (periph_level[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Package dependent alternate pin for pwm2 output B

	// Small package: alternate is port_b_pin5; large package uses port D pin 2
	always_comb begin
		for (int i = 0; i < NUM_FUNC; i++) begin
			pin_ovr_dflt[i] = route_dflt[i];
			pin_ovr_alt[i]  = route_alt[i];
		end
		port_d_pin2_ovr = '0;
		if (SMALL_PKG) begin
			pin_ovr_alt[`APR_SEL_PWM2_B] = route_alt[`APR_SEL_PWM2_B];
		end else begin
			pin_ovr_alt[`APR_SEL_PWM2_B] = '0;
			port_d_pin2_ovr              = route_alt[`APR_SEL_PWM2_B];
		end
	end

endmodule : apr_pin_steer

/* verif/apr_pin_steer_assertions.sv */
// Port checker for the alternate pin router
`timescale 1ns/100ps
module apr_pin_steer_assertions #(
	parameter int NUM_FUNC = 7
) (
	// Bus
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic [31:0]           hwdata,
	input wire logic                  hready,
	input wire logic                  hreadyout,
	input wire logic [31:0]           hrdata,
	input wire logic                  hresp,
	// Steering
	input wire apr_pkg::apr_pin_ovr_t periph_drive [NUM_FUNC],
	input wire logic                  periph_level [NUM_FUNC],
	input wire logic                  pin_level_dflt [NUM_FUNC],
	input wire logic                  pin_level_alt [NUM_FUNC],
	input wire apr_pkg::apr_pin_ovr_t pin_ovr_dflt [NUM_FUNC],
	input wire apr_pkg::apr_pin_ovr_t pin_ovr_alt [NUM_FUNC],
	input wire apr_pkg::apr_pin_ovr_t port_d_pin2_ovr
);
	logic       wr_ph;
	logic       rd_ph;
	logic [6:0] sel_m;
	// Mirror of the control register, tracked from bus traffic alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'b0;
			rd_ph <= 1'b0;
			sel_m <= 7'h00;
		end else begin
			wr_ph <= hsel && hready && htrans[1] && hwrite && haddr[11:2] == 10'h000;
			rd_ph <= hsel && hready && htrans[1] && !hwrite && haddr[11:2] == 10'h000;
			if (wr_ph)
				sel_m <= hwdata[6:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp) else $error("bus answer not okay");
	a_ctrl_read: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_ph |-> hrdata == {25'h0, sel_m}) else $error("control readback wrong");
	a_reset_quiet: assert property (@(posedge hclk)
		!hresetn |-> hrdata == 32'h0 && pin_ovr_alt[4] == 4'h0) else $error("reset not quiet");
	a_port_d_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		port_d_pin2_ovr == 4'h0) else $error("large package pin driven");
	for (genvar i = 0; i < NUM_FUNC; i++) begin : g_fn
		a_alt_follow: assert property (@(posedge hclk) disable iff (!hresetn)
			$past(hresetn) |-> pin_ovr_alt[i] == ($past(sel_m[i]) ? $past(periph_drive[i]) : 4'h0))
			else $error("alternate override wrong");
		a_dflt_follow: assert property (@(posedge hclk) disable iff (!hresetn)
			$past(hresetn) |-> pin_ovr_dflt[i] == ($past(sel_m[i]) ? 4'h0 : $past(periph_drive[i])))
			else $error("default override wrong");
		a_level_pick: assert property (@(posedge hclk) disable iff (!hresetn)
			$past(hresetn) |-> periph_level[i] ==
			($past(sel_m[i]) ? $past(pin_level_alt[i]) : $past(pin_level_dflt[i])))
			else $error("input level from wrong pin");
		a_dir_kept: assert property (@(posedge hclk) disable iff (!hresetn)
			$past(hresetn) |-> (pin_ovr_dflt[i].dir_val | pin_ovr_alt[i].dir_val)
			== $past(periph_drive[i].dir_val)) else $error("direction value altered");
	end
endmodule : apr_pin_steer_assertions

/* verif/apr_far_side.sv */
// Model of the peripherals and port pins around the router
`timescale 1ns/100ps
module apr_far_side (
	// Clock
	input  wire logic             hclk,
	// Peripheral requests and pin levels
	output apr_pkg::apr_pin_ovr_t periph_drive [7],
	output logic                  pin_level_dflt [7],
	output logic                  pin_level_alt [7]
);
	logic [7:0] cnt = 8'h00;
	// Drive pattern moves every cycle so a stale drive value never looks right; pin levels follow counter bit i and the inverse of bit i + 1
	always @(posedge hclk)
		cnt <= cnt + 8'h01;
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			periph_drive[i] = cnt[3:0] ^ 4'(i);
			pin_level_dflt[i] = cnt[i];
			pin_level_alt[i] = ~cnt[i + 1];
		end
	end
endmodule : apr_far_side

/* verif/apr_pin_steer_tb.sv */
// Self-checking bench for the alternate pin router
`timescale 1ns/100ps
module apr_pin_steer_tb;
	logic                  hclk = 1'b0;
	logic                  hresetn = 1'b1;
	logic                  hsel = 1'b0;
	logic [31:0]           haddr = 32'h0;
	logic [1:0]            htrans = 2'h0;
	logic                  hwrite = 1'b0;
	logic [31:0]           hwdata = 32'h0;
	logic                  hreadyout;
	logic [31:0]           hrdata;
	logic                  hresp;
	apr_pkg::apr_pin_ovr_t periph_drive [7];
	logic                  periph_level [7];
	logic                  pin_level_dflt [7];
	logic                  pin_level_alt [7];
	apr_pkg::apr_pin_ovr_t pin_ovr_dflt [7];
	apr_pkg::apr_pin_ovr_t pin_ovr_alt [7];
	apr_pkg::apr_pin_ovr_t port_d_pin2_ovr;
	int                    n_fail = 0;
	int                    n_compared = 0;
	logic [31:0]           rd;

	initial forever #2 hclk = ~hclk;
	apr_far_side far_u (
		.hclk           (hclk),
		.periph_drive   (periph_drive),
		.pin_level_dflt (pin_level_dflt),
		.pin_level_alt  (pin_level_alt)
	);
	apr_pin_steer dut_u (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.hsel            (hsel),
		.haddr           (haddr),
		.htrans          (htrans),
		.hwrite          (hwrite),
		.hsize           (3'h2),
		.hwdata          (hwdata),
		.hready          (hreadyout),
		.hreadyout       (hreadyout),
		.hrdata          (hrdata),
		.hresp           (hresp),
		.periph_drive    (periph_drive),
		.periph_level    (periph_level),
		.pin_level_dflt  (pin_level_dflt),
		.pin_level_alt   (pin_level_alt),
		.pin_ovr_dflt    (pin_ovr_dflt),
		.pin_ovr_alt     (pin_ovr_alt),
		.port_d_pin2_ovr (port_d_pin2_ovr)
	);
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Bounded wait for hready at a rising edge
	task wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			end_sim;
		end
	endtask : wait_rdy

	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask : bus

	// Capture what the router samples at a rising edge, check its outputs at the falling one
	task chk_pins(input logic [6:0] s);
		apr_pkg::apr_pin_ovr_t d [7];
		logic                  la [7];
		logic                  ld [7];
		@(posedge hclk);
		d = periph_drive;
		la = pin_level_alt;
		ld = pin_level_dflt;
		@(negedge hclk);
		for (int i = 0; i < 7; i++) begin
			chk(32'(pin_ovr_alt[i]), s[i] ? 32'(d[i]) : 32'h0);
			chk(32'(pin_ovr_dflt[i]), s[i] ? 32'h0 : 32'(d[i]));
			chk(32'(periph_level[i]), 32'(s[i] ? la[i] : ld[i]));
		end
		chk(32'(port_d_pin2_ovr), 32'h0);
		@(posedge hclk);
	endtask : chk_pins

	initial begin
		hresetn <= 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(rd, 32'h0);
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, 32'h0, 32'h1 << i, rd);
			bus(1'b0, 32'h0, 32'h0, rd);
			chk(rd, 32'h1 << i);
			bus(1'b0, 32'h4, 32'h0, rd);
			chk({25'h0, rd[6:0]}, 32'h1 << i);
			chk_pins(7'(32'h1 << i));
		end
		bus(1'b1, 32'h0, 32'hffff_ffff, rd);
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(rd, 32'h7f);
		chk_pins(7'h7f);
		// Unmapped place: reads zero, write must not reach control
		bus(1'b1, 32'h10, 32'h0, rd);
		bus(1'b0, 32'h10, 32'h0, rd);
		chk(rd, 32'h0);
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(rd, 32'h7f);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0, 32'h0, rd);
		chk(rd, 32'h0);
		chk_pins(7'h00);
		end_sim;
	end
endmodule : apr_pin_steer_tb

bind apr_pin_steer apr_pin_steer_assertions #(.NUM_FUNC(NUM_FUNC)) chk_u (
	.hclk            (hclk),
	.hresetn         (hresetn),
	.hsel            (hsel),
	.haddr           (haddr),
	.htrans          (htrans),
	.hwrite          (hwrite),
	.hwdata          (hwdata),
	.hready          (hready),
	.hreadyout       (hreadyout),
	.hrdata          (hrdata),
	.hresp           (hresp),
	.periph_drive    (periph_drive),
	.periph_level    (periph_level),
	.pin_level_dflt  (pin_level_dflt),
	.pin_level_alt   (pin_level_alt),
	.pin_ovr_dflt    (pin_ovr_dflt),
	.pin_ovr_alt     (pin_ovr_alt),
	.port_d_pin2_ovr (port_d_pin2_ovr)
);
